// [bench/crc_protected_i2c_target_props.sv]
`timescale 1ns/1ps
`default_nettype none
// watches the link shared by the controller and the target
module crc_protected_i2c_target_props (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic ctl_scl_out,
	input wire logic ctl_scl_oe,
	input wire logic ctl_sda_out,
	input wire logic ctl_sda_oe,
	input wire logic tgt_sda_out,
	input wire logic tgt_sda_oe
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	logic [7:0] since_rise; // cycles since last scl rise, saturating
	// counter instead of a long repetition keeps the tools quick
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			since_rise <= 8'hFF;
		end else if (scl && !$past(scl)) begin
			since_rise <= 8'h00;
		end else if (since_rise != 8'hFF) begin
			since_rise <= since_rise + 8'h01;
		end
	end
	// open drain: an enabled driver only ever pulls low
	property p_ctl_open_drain;
		(ctl_scl_oe || ctl_sda_oe) |-> !(ctl_scl_oe && ctl_scl_out) && !(ctl_sda_oe && ctl_sda_out);
	endproperty
	a_ctl_open_drain: assert property (p_ctl_open_drain) else $error("controller drives a high");
	property p_tgt_open_drain;
		tgt_sda_oe |-> !tgt_sda_out;
	endproperty
	a_tgt_open_drain: assert property (p_tgt_open_drain) else $error("target drives a high");
	property p_scl_high_min;
		$rose(scl) |-> scl [*8];
	endproperty
	a_scl_high_min: assert property (p_scl_high_min) else $error("scl high phase too short");
	property p_scl_low_min;
		$fell(scl) |-> !scl [*8];
	endproperty
	a_scl_low_min: assert property (p_scl_low_min) else $error("scl low phase too short");
	property p_scl_low_max;
		$fell(scl) |-> ##[1:40] scl;
	endproperty
	a_scl_low_max: assert property (p_scl_low_max) else $error("scl held low too long");
	// 3.4 MHz means at least 59 cycles from one rise to the next
	property p_bit_rate;
		$rose(scl) |-> since_rise >= 8'h3A;
	endproperty
	a_bit_rate: assert property (p_bit_rate) else $error("scl faster than allowed");
	property p_sda_stable_high;
		$rose(scl) |=> $stable(sda) [*8];
	endproperty
	a_sda_stable_high: assert property (p_sda_stable_high) else $error("sda moved under scl high");
	property p_tgt_moves_low;
		$changed(tgt_sda_oe) |-> !scl;
	endproperty
	a_tgt_moves_low: assert property (p_tgt_moves_low) else $error("target moved sda with scl high");
endmodule // crc_protected_i2c_target_props
`default_nettype wire

// [bench/crc_protected_i2c_target_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module crc_protected_i2c_target_tb import crc_i2c_pkg::*;;
	localparam int QC = int'(SCL_QUARTER_CYCLES); // cycles per quarter bit
	localparam logic [3:0] TGT_AB = 4'hA; // config bits of the first target
	logic clock_in, rst_in, ce, hs, hs_b, cmd_valid, cmd_read, cmd_space;
	logic [3:0] cmd_ab;
	logic [5:0] cmd_reg, wr_reg, rd_reg, wr_reg_b;
	logic [15:0] cmd_data, rd_data, wr_data, wr_data_b, ctl_rd_data;
	logic wr_valid, space_sel, rd_req, rd_space, comm_err, wr_valid_b, space_b, comm_err_b;
	logic cmd_ready, done, nack, crc_err;
	logic [23:0] wq [$]; // expected target events {read, space, reg, data}
	logic [23:0] rq [$]; // expected events of the second target {error, space, reg, data}
	logic [18:0] dq [$]; // expected controller results {read, nack, crc error, data}
	logic [18:0] e_d;
	logic [15:0] last_rd; // read data the controller should still be holding
	int fail_count, compares, seed;
	// known-good frames, a corrupted crc, and spike widths per frame
	logic [39:0] frames [4] = '{40'h40_0200_0031, 40'h42_01D0_0D8C, 40'h42_01D0_0D8D,
		40'h40_0200_0031};
	logic [23:0] exp_b [4] = '{24'h02_0000, 24'h41_D00D, 24'h80_0000, 24'h02_0000};
	int spikes [4] = '{0, 8, 0, 1};
	i2c_link_if link();
	i2c_link_if link_b(); // driven by hand to break the rules on purpose
	crc_i2c_controller u_crc_i2c_controller (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce),
		.cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read), .cmd_space_in(cmd_space),
		.target_address_bits_in(cmd_ab), .cmd_reg_in(cmd_reg), .cmd_data_in(cmd_data),
		.link(link), .cmd_ready_out(cmd_ready), .done_out(done), .nack_out(nack),
		.crc_err_out(crc_err), .rd_data_out(ctl_rd_data), .scl_out(), .scl_oe_out(),
		.sda_out(), .sda_oe_out());
	crc_i2c_target u_crc_i2c_target (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce),
		.hs_mode_in(hs), .target_address_bits_in(TGT_AB), .rd_data_in(rd_data), .link(link),
		.wr_valid_out(wr_valid), .logic_space_select_out(space_sel), .wr_reg_out(wr_reg),
		.wr_data_out(wr_data), .rd_req_out(rd_req), .rd_space_out(rd_space),
		.rd_reg_out(rd_reg), .comm_error_out(comm_err), .sda_out(), .sda_oe_out());
	crc_i2c_target u_crc_i2c_target_b (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce),
		.hs_mode_in(hs_b), .target_address_bits_in(4'h0), .rd_data_in(rd_data),
		.link(link_b), .wr_valid_out(wr_valid_b), .logic_space_select_out(space_b),
		.wr_reg_out(wr_reg_b), .wr_data_out(wr_data_b), .rd_req_out(), .rd_space_out(),
		.rd_reg_out(), .comm_error_out(comm_err_b), .sda_out(), .sda_oe_out());
	crc_protected_i2c_target_props u_props (.clock_in(clock_in), .rst_in(rst_in),
		.scl(link.scl), .sda(link.sda), .ctl_scl_out(link.ctl_scl_out),
		.ctl_scl_oe(link.ctl_scl_oe), .ctl_sda_out(link.ctl_sda_out),
		.ctl_sda_oe(link.ctl_sda_oe), .tgt_sda_out(link.tgt_sda_out),
		.tgt_sda_oe(link.tgt_sda_oe));
	// 200 MHz system clock
	always #2.5 clock_in = ~clock_in;
	// compare tasks, one per kind of result
	task automatic compare_w(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic compare_d(input string what, input logic [18:0] exp, input logic [18:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// wait n edges, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	// one command through the controller; waits for its done pulse, bounded
	task automatic run_cmd(input logic rd, input logic sp, input logic [3:0] ab,
		input logic [5:0] rg, input logic [15:0] dt);
		int n;
		logic hit;
		hit = (ab === TGT_AB);
		if (hit) wq.push_back({rd, sp, rg, rd ? 16'h0000 : dt});
		// a refused read or any write leaves the last good read data in place
		if (hit && rd) last_rd = rd_data;
		dq.push_back({rd, !hit, 1'b0, last_rd});
		{cmd_read, cmd_space, cmd_ab, cmd_reg, cmd_data} = {rd, sp, ab, rg, dt};
		cmd_valid = 1'b1;
		tick(1);
		cmd_valid = 1'b0;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (done !== 1'b1 && n < 20000);
		if (done !== 1'b1) fail_count++; // limit ran out without a done pulse
	endtask
	// bit on the hand-driven link; an optional spike raises scl mid low phase
	task automatic rogue_bit(input logic b, input int spike);
		link_b.ctl_scl_oe = 1'b1;
		tick(QC);
		link_b.ctl_sda_oe = !b;
		if (spike > 0) begin
			tick(3);
			link_b.ctl_scl_oe = 1'b0;
			tick(spike);
			link_b.ctl_scl_oe = 1'b1;
			tick(QC - 3 - spike);
		end else begin
			tick(QC);
		end
		link_b.ctl_scl_oe = 1'b0;
		tick(2 * QC);
	endtask
	task automatic rogue_frame(input logic [39:0] f, input int spike);
		tick(QC);
		link_b.ctl_sda_oe = 1'b1; // start with scl high
		tick(QC);
		for (int i = 39; i >= 0; i--) begin
			rogue_bit(f[i], (i == 23) ? spike : 0);
			if (i % 8 == 0) rogue_bit(1'b1, 0); // released for the ack
		end
		link_b.ctl_scl_oe = 1'b1;
		tick(QC);
		link_b.ctl_sda_oe = 1'b1;
		tick(QC);
		link_b.ctl_scl_oe = 1'b0;
		tick(QC);
		link_b.ctl_sda_oe = 1'b0; // stop
		tick(4 * QC);
	endtask
	// result watcher: oldest note against each result as it appears
	always @(posedge clock_in) begin
		if (wr_valid === 1'b1) compare_w("write", wq.size() ? wq.pop_front() : 24'hFFFFFF,
			{1'b0, space_sel, wr_reg, wr_data});
		if (rd_req === 1'b1) compare_w("read request", wq.size() ? wq.pop_front() : 24'hFFFFFF,
			{1'b1, rd_space, rd_reg, 16'h0000});
		if (wr_valid_b === 1'b1) compare_w("second write", rq.size() ? rq.pop_front() : 24'hFFFFFF,
			{1'b0, space_b, wr_reg_b, wr_data_b});
		if (comm_err_b === 1'b1) compare_w("second error", rq.size() ? rq.pop_front() : 24'hFFFFFF,
			24'h80_0000);
		if (done === 1'b1) begin
			e_d = dq.size() ? dq.pop_front() : 19'h7FFFF;
			compare_d("result", e_d, {e_d[18], nack, crc_err, ctl_rd_data});
		end
	end
	// watchdog: the whole sequence needs well under 90000 cycles
	initial begin
		repeat (90000) @(posedge clock_in);
		fail_count++;
		complete_run();
	end
	// main sequence
	initial begin
		{clock_in, rst_in, ce, hs, hs_b, cmd_valid, cmd_read, cmd_space} = 8'h78;
		{cmd_ab, cmd_reg, cmd_data, rd_data, last_rd} = '0;
		{link_b.ctl_scl_out, link_b.ctl_scl_oe, link_b.ctl_sda_out, link_b.ctl_sda_oe} = 4'h0;
		fail_count = 0;
		compares = 0;
		seed = 32'h1041;
		tick(3);
		rst_in = 1'b0;
		tick(2);
		// both spaces, both directions, both filters, end registers, foreign address
		for (int k = 0; k < 8; k++) begin
			hs = k[2];
			rd_data = 16'($random(seed));
			run_cmd(k[0], k[1], (k == 5 || k == 6) ? ~TGT_AB : TGT_AB,
				(k == 2) ? 6'h3F : (k == 3) ? 6'h00 : 6'($random(seed)),
				16'($random(seed)));
			tick(3);
		end
		// fixed frames by hand: known crc values, spikes, a bad crc
		for (int k = 0; k < 4; k++) begin
			hs_b = (k == 3);
			rq.push_back(exp_b[k]);
			rogue_frame(frames[k], spikes[k]);
		end
		tick(100);
		compare_d("pending", 19'h0, 19'(wq.size() + dq.size() + rq.size()));
		complete_run();
	end
endmodule // crc_protected_i2c_target_tb
`default_nettype wire

// [logic/crc_i2c_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module crc_i2c_controller import crc_i2c_pkg::*; (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_read_in,
	input wire logic cmd_space_in,
	input wire logic [3:0] target_address_bits_in,
	input wire logic [5:0] cmd_reg_in,
	input wire logic [15:0] cmd_data_in,
	i2c_link_if.controller link,
	output logic cmd_ready_out,
	output logic done_out,
	output logic nack_out,
	output logic crc_err_out,
	output logic [15:0] rd_data_out,
	output logic scl_out,
	output logic scl_oe_out,
	output logic sda_out,
	output logic sda_oe_out
);
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_START = 3'h1,
		H_BIT = 3'h3,
		H_RESTART = 3'h2,
		H_STOP = 3'h6
	} hstate_t;

	hstate_t state; // sequencer state
	logic [4:0] div; // quarter-bit divider
	logic tick; // start of a quarter
	logic [1:0] q; // quarter within bit
	logic [3:0] bitn; // 0..7 data, 8 ack
	logic [2:0] byten; // byte within sequence
	logic is_rd, space; // latched command
	logic [5:0] reg_a;
	logic [15:0] data;
	logic [23:0] rx; // received data and crc
	logic sda_s1, sda_s2; // synchronised bus data
	logic [6:0] addr7;
	logic [7:0] tx_byte; // byte sent in this slot
	logic rx_slot; // this byte comes from the target
	logic last_byte;
	logic tx_bit;

	assign link.ctl_scl_out = scl_out;
	assign link.ctl_scl_oe = scl_oe_out;
	assign link.ctl_sda_out = sda_out;
	assign link.ctl_sda_oe = sda_oe_out;
	// four quarters per bit hold the bit rate at or under the limit
	assign tick = (div == SCL_QUARTER_CYCLES - 5'h1); // [R1]
	assign addr7 = {ADDR_PREFIX, target_address_bits_in, space}; // [R3] [R4]
	assign rx_slot = is_rd && (byten > HOST_LAST_RD - 3'h3);
	assign last_byte = byten == (is_rd ? HOST_LAST_RD : HOST_LAST_WR);
	assign tx_bit = tx_byte[3'(4'h7 - bitn)];

	// byte for this slot, msb first
	always_comb begin
		tx_byte = 8'h00;
		case (byten)
			3'h0: tx_byte = {addr7, RW_WRITE}; // [R5] [R11]
			3'h1: tx_byte = {REG_PAD, reg_a};
			3'h2: tx_byte = is_rd ? {addr7, RW_READ} : data[15:8];
			3'h3: tx_byte = data[7:0];
			3'h4: tx_byte = crc8({addr7, RW_WRITE, REG_PAD, reg_a, data}); // [R6]
			default: tx_byte = 8'h00;
		endcase
	end

	// data pin passes two flops; clock pin is ours and not read back
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else if (ce_in) begin
			sda_s1 <= link.sda;
			sda_s2 <= sda_s1;
		end
	end

	// divider runs only while a sequence is active
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			div <= 5'h00;
		end else if (ce_in) begin
			div <= (state == H_IDLE || tick) ? 5'h00 : div + 5'h01;
		end
	end

	// sequencer
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state <= H_IDLE;
			q <= 2'h0;
			bitn <= 4'h0;
			byten <= 3'h0;
			is_rd <= 1'b0;
			space <= 1'b0;
			reg_a <= 6'h00;
			data <= 16'h0000;
			rx <= 24'h00_0000;
			cmd_ready_out <= 1'b1;
			done_out <= 1'b0;
			nack_out <= 1'b0;
			crc_err_out <= 1'b0;
			rd_data_out <= 16'h0000;
			scl_out <= 1'b0;
			scl_oe_out <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			if (state == H_IDLE) begin
				if (cmd_valid_in && cmd_ready_out) begin
					is_rd <= cmd_read_in;
					space <= cmd_space_in;
					reg_a <= cmd_reg_in;
					data <= cmd_data_in;
					cmd_ready_out <= 1'b0;
					nack_out <= 1'b0;
					crc_err_out <= 1'b0;
					q <= 2'h0;
					state <= H_START;
				end
			end else if (tick) begin
				q <= q + 2'h1;
				case (state)
					H_START: begin
						// pull data low while the clock is high
						if (q == 2'h1) begin
							sda_oe_out <= 1'b1;
						end
						if (q == 2'h3) begin
							bitn <= 4'h0;
							byten <= 3'h0;
							state <= H_BIT;
						end
					end
					H_BIT: begin
						case (q)
							2'h0: scl_oe_out <= 1'b1;
							2'h1: begin
								if (bitn != 4'h8) begin
									sda_oe_out <= ~rx_slot & ~tx_bit; // [R11]
								end else begin
									// ack target bytes except the last
									sda_oe_out <= rx_slot & ~last_byte;
								end
							end
							2'h2: scl_oe_out <= 1'b0;
							default: begin
								if (bitn != 4'h8) begin
									bitn <= bitn + 4'h1;
									if (rx_slot) begin
										rx <= {rx[22:0], sda_s2};
									end
								end else begin
									bitn <= 4'h0;
									byten <= byten + 3'h1;
									if (!rx_slot && sda_s2) begin
										nack_out <= 1'b1;
										state <= H_STOP;
									end else if (last_byte) begin
										state <= H_STOP;
									end else if (is_rd && byten == 3'h1) begin
										state <= H_RESTART;
									end
								end
							end
						endcase
					end
					H_RESTART: begin
						case (q)
							2'h0: scl_oe_out <= 1'b1;
							2'h1: sda_oe_out <= 1'b0;
							2'h2: scl_oe_out <= 1'b0;
							default: begin
								sda_oe_out <= 1'b1;
								state <= H_BIT;
							end
						endcase
					end
					H_STOP: begin
						case (q)
							2'h0: scl_oe_out <= 1'b1;
							2'h1: sda_oe_out <= 1'b1;
							2'h2: scl_oe_out <= 1'b0;
							default: begin
								sda_oe_out <= 1'b0;
								done_out <= 1'b1;
								cmd_ready_out <= 1'b1;
								state <= H_IDLE;
								if (is_rd && !nack_out) begin
									rd_data_out <= rx[23:8];
									crc_err_out <= rx[7:0] !=
										crc8({addr7, RW_READ, REG_PAD, reg_a, rx[23:8]}); // [R12]
								end
							end
						endcase
					end
					default: state <= H_IDLE;
				endcase
			end
		end
	end
endmodule // crc_i2c_controller
`default_nettype wire

// [logic/crc_i2c_pkg.sv]
`default_nettype none
package crc_i2c_pkg;
	// system clock
	localparam int CLK_PERIOD_PS = 5000;
	// fastest bus clock in kHz and the resulting least period
	localparam int SCL_MAX_KHZ = 3400;
	localparam int SCL_MIN_PERIOD_PS = 1000000000 / SCL_MAX_KHZ;
	// one quarter of a bus bit, rounded up so the bus never runs too fast
	localparam logic [4:0] SCL_QUARTER_CYCLES =
		5'((SCL_MIN_PERIOD_PS + 4 * CLK_PERIOD_PS - 1) / (4 * CLK_PERIOD_PS));
	// spike filter widths
	localparam int FILT_FS_NS = 50;
	localparam int FILT_HS_NS = 10;
	localparam logic [3:0] FILT_FS_CYCLES =
		4'((FILT_FS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [3:0] FILT_HS_CYCLES =
		4'((FILT_HS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	// address byte layout
	localparam logic [1:0] ADDR_PREFIX = 2'h1;
	localparam logic SPACE_MAIN = 1'b0;
	localparam logic SPACE_FAILSAFE = 1'b1;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	localparam logic [1:0] REG_PAD = 2'h0;
	// crc
	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_SEED = 8'hFF;
	// byte positions within a write frame
	localparam logic [2:0] BYTE_ADDR = 3'h0;
	localparam logic [2:0] BYTE_REG = 3'h1;
	localparam logic [2:0] BYTE_DHI = 3'h2;
	localparam logic [2:0] BYTE_DLO = 3'h3;
	localparam logic [2:0] BYTE_CRC = 3'h4;
	localparam logic [2:0] BYTE_LIMIT = 3'h5;
	// last byte index of a write and of a read sequence
	localparam logic [2:0] HOST_LAST_WR = 3'h4;
	localparam logic [2:0] HOST_LAST_RD = 3'h5;
	// bytes sent back by the target on a read after the first one
	localparam logic [1:0] TX_BYTES_AFTER_FIRST = 2'h2;

	// serial crc, msb first; equals the eight parallel xor equations
	function automatic logic [7:0] crc8(input logic [31:0] bits);
		logic [7:0] crc;
		logic fb;
		crc = CRC_SEED; // [R7]
		for (int i = 31; i >= 0; i--) begin
			fb = crc[7] ^ bits[i];
			crc = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00); // [R7] [R8]
		end
		return crc;
	endfunction
endpackage
`default_nettype wire

// [logic/crc_i2c_target.sv]
// Function
// [R1] bus runs at up to 3.4 Mbit/s
// [R2] two target addresses: main and fail-safe
// [R3] address is 0, 1, four config bits, select
// [R4] select bit 0 main, 1 fail-safe
// [R5] controller addresses target on every transaction
// [R6] every write and read carries crc byte
// [R7] crc polynomial 0x1D, preset to all ones
// [R8] parallel xor form equals serial crc
// [R9] 50 ns spike filter in fast modes
// [R10] 10 ns spike filter in high speed
// [R11] msb first: address, rw, register, data, crc
// [R12] bad crc write dropped, error flagged; reads crc'd
`timescale 1ns/1ps
`default_nettype none
module crc_i2c_target import crc_i2c_pkg::*; (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic hs_mode_in,
	input wire logic [3:0] target_address_bits_in,
	input wire logic [15:0] rd_data_in,
	i2c_link_if.target link,
	output logic wr_valid_out,
	output logic logic_space_select_out,
	output logic [5:0] wr_reg_out,
	output logic [15:0] wr_data_out,
	output logic rd_req_out,
	output logic rd_space_out,
	output logic [5:0] rd_reg_out,
	output logic comm_error_out,
	output logic sda_out,
	output logic sda_oe_out
);
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_RECV = 3'h1,
		D_ACK = 3'h3,
		D_ACKH = 3'h2,
		D_SEND = 3'h6,
		D_HACK = 3'h7
	} dstate_t;
	logic [1:0] line_raw; // scl, sda as seen on the pins
	logic [1:0] filt; // filtered levels
	logic [1:0] filt_d; // previous filtered levels
	logic [3:0] flt_len; // filter width in cycles
	dstate_t state; // byte engine state
	logic [2:0] bitcnt; // bit within byte
	logic [2:0] byte_idx; // byte within frame
	logic [7:0] shreg; // incoming byte
	logic [7:0] new_byte; // byte completed by this rising edge
	logic [31:0] frame; // address, register, data
	logic [23:0] tx_sh; // outgoing data and crc
	logic [1:0] tx_left; // bytes still to send after current
	logic ack_it; // ack the byte just received
	logic have_reg; // register byte held for a following read
	logic host_acked; // controller acked the byte we sent
	logic addr_hit; // address byte matches ours
	logic crc_ok; // received crc matches frame
	logic scl_f, sda_f, scl_rise, scl_fall, bus_start, bus_stop;
	assign line_raw = {link.scl, link.sda};
	assign link.tgt_sda_out = sda_out;
	assign link.tgt_sda_oe = sda_oe_out;
	// the narrow filter is needed at 3.4 Mbit/s, the wide one would eat bits
	assign flt_len = hs_mode_in ? FILT_HS_CYCLES : FILT_FS_CYCLES; // [R1] [R9] [R10]
	// per line: two-flop synchroniser then a stability filter
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_line
			logic s1, s2, f;
			logic [3:0] cnt;
			assign filt[g] = f;
			always_ff @(posedge clock_in or posedge rst_in) begin
				if (rst_in) begin
					s1 <= 1'b1;
					s2 <= 1'b1;
					f <= 1'b1;
					cnt <= 4'h0;
				end else if (ce_in) begin
					s1 <= line_raw[g];
					s2 <= s1;
					// a level must hold flt_len cycles before it passes
					if (s2 == f) begin
						cnt <= 4'h0;
					end else if (cnt >= flt_len - 4'h1) begin
						f <= s2; // [R9] [R10]
						cnt <= 4'h0;
					end else begin
						cnt <= cnt + 4'h1;
					end
				end
			end
		end
	endgenerate
	// previous filtered levels for edge detection
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			filt_d <= 2'h3;
		end else if (ce_in) begin
			filt_d <= filt;
		end
	end
	assign scl_f = filt[1];
	assign sda_f = filt[0];
	assign scl_rise = scl_f & ~filt_d[1];
	assign scl_fall = ~scl_f & filt_d[1];
	// start and stop: data moves while clock stays high
	assign bus_start = scl_f & filt_d[1] & filt_d[0] & ~sda_f;
	assign bus_stop = scl_f & filt_d[1] & ~filt_d[0] & sda_f;
	assign new_byte = {shreg[6:0], sda_f}; // [R11]
	// both spaces answer; only the select bit differs
	assign addr_hit = (new_byte[7:6] == ADDR_PREFIX) &&
		(new_byte[5:2] == target_address_bits_in); // [R2] [R3]
	assign crc_ok = (new_byte == crc8(frame)); // [R6] [R12]
	// byte engine
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			sda_out <= 1'b0; // open drain: only ever pull low, never set high
			state <= D_IDLE;
			bitcnt <= 3'h0;
			byte_idx <= 3'h0;
			shreg <= 8'h00;
			frame <= 32'h0000_0000;
			tx_sh <= 24'h00_0000;
			tx_left <= 2'h0;
			ack_it <= 1'b0;
			have_reg <= 1'b0;
			host_acked <= 1'b0;
			sda_oe_out <= 1'b0;
			wr_valid_out <= 1'b0;
			logic_space_select_out <= 1'b0;
			wr_reg_out <= 6'h00;
			wr_data_out <= 16'h0000;
			rd_req_out <= 1'b0;
			rd_space_out <= 1'b0;
			rd_reg_out <= 6'h00;
			comm_error_out <= 1'b0;
		end else if (ce_in) begin
			// strobes last one cycle
			wr_valid_out <= 1'b0;
			rd_req_out <= 1'b0;
			comm_error_out <= 1'b0;
			if (bus_start) begin
				// start or repeated start: every frame begins with an address
				state <= D_RECV; // [R5]
				bitcnt <= 3'h0;
				byte_idx <= BYTE_ADDR;
				sda_oe_out <= 1'b0;
			end else if (bus_stop) begin
				// a stop ends any pending read setup
				state <= D_IDLE;
				have_reg <= 1'b0;
				sda_oe_out <= 1'b0;
			end else begin
				case (state)
					D_RECV: begin
						if (scl_rise) begin
							shreg <= new_byte; // [R11]
							bitcnt <= bitcnt + 3'h1;
							if (bitcnt == 3'h7) begin
								state <= D_ACK;
								if (byte_idx != BYTE_LIMIT) begin
									byte_idx <= byte_idx + 3'h1;
								end
								case (byte_idx)
									BYTE_ADDR: begin
										if (addr_hit) begin
											frame[31:24] <= new_byte;
											// a read needs the register sent before
											ack_it <= (new_byte[0] == RW_WRITE) | have_reg;
											if ((new_byte[0] == RW_READ) && have_reg) begin
												rd_req_out <= 1'b1;
												rd_space_out <= new_byte[1]; // [R4]
												rd_reg_out <= frame[21:16];
											end
										end else begin // another target's address: stay silent
											state <= D_IDLE;
										end
									end
									BYTE_REG: begin
										frame[23:16] <= new_byte; // [R11]
										have_reg <= 1'b1;
										ack_it <= 1'b1;
									end
									BYTE_DHI: begin
										frame[15:8] <= new_byte; // [R11]
										have_reg <= 1'b0;
										ack_it <= 1'b1;
									end
									BYTE_DLO: begin
										frame[7:0] <= new_byte;
										ack_it <= 1'b1;
									end
									BYTE_CRC: begin // nack and drop on mismatch
										ack_it <= crc_ok; // [R12]
										if (crc_ok) begin
											wr_valid_out <= 1'b1;
											logic_space_select_out <= frame[25]; // [R4]
											wr_reg_out <= frame[21:16];
											wr_data_out <= frame[15:0];
										end else begin
											comm_error_out <= 1'b1; // [R12]
										end
									end
									default: begin // bytes past the crc are refused
										ack_it <= 1'b0;
									end
								endcase
							end
						end
					end
					D_ACK: begin
						if (scl_fall) begin
							sda_oe_out <= ack_it;
							state <= D_ACKH;
						end
					end
					D_ACKH: begin
						if (scl_fall) begin
							sda_oe_out <= 1'b0;
							bitcnt <= 3'h0;
							if (!ack_it) begin
								state <= D_IDLE;
							end else if (frame[24] && (byte_idx == BYTE_REG)) begin
								// read: return data and crc over the returned frame
								state <= D_SEND;
								tx_sh <= {rd_data_in,
									crc8({frame[31:16], rd_data_in})}; // [R6] [R12]
								sda_oe_out <= ~rd_data_in[15];
								tx_left <= TX_BYTES_AFTER_FIRST;
								have_reg <= 1'b0;
							end else begin
								state <= D_RECV;
							end
						end
					end
					D_SEND: begin // data changes only while the clock is low
						if (scl_fall) begin
							tx_sh <= {tx_sh[22:0], 1'b0};
							if (bitcnt == 3'h7) begin
								sda_oe_out <= 1'b0;
								bitcnt <= 3'h0;
								state <= D_HACK;
							end else begin
								bitcnt <= bitcnt + 3'h1;
								sda_oe_out <= ~tx_sh[22]; // [R11]
							end
						end
					end
					D_HACK: begin
						if (scl_rise) begin
							if (!sda_f && (tx_left != 2'h0)) begin
								host_acked <= 1'b1;
							end else begin
								state <= D_IDLE;
							end
						end else if (scl_fall && host_acked) begin
							host_acked <= 1'b0;
							tx_left <= tx_left - 2'h1;
							sda_oe_out <= ~tx_sh[23];
							state <= D_SEND;
						end
					end
					default: begin
						state <= D_IDLE;
					end
				endcase
			end
		end
	end
endmodule // crc_i2c_target
`default_nettype wire

// [logic/i2c_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
	// open-drain drives; the wire is low when any enabled driver pulls it
	logic ctl_scl_out;
	logic ctl_scl_oe;
	logic ctl_sda_out;
	logic ctl_sda_oe;
	logic tgt_sda_out;
	logic tgt_sda_oe;
	// resolved bus levels with pull-ups
	logic scl;
	logic sda;
	assign scl = ctl_scl_oe ? ctl_scl_out : 1'b1;
	assign sda = (ctl_sda_oe ? ctl_sda_out : 1'b1) & (tgt_sda_oe ? tgt_sda_out : 1'b1);
	modport target (input scl, input sda, output tgt_sda_out, output tgt_sda_oe);
	modport controller (input scl, input sda, output ctl_scl_out, output ctl_scl_oe,
		output ctl_sda_out, output ctl_sda_oe);
endinterface
`default_nettype wire
